// ===== design/pmw_cpu_gate.sv
// Per-CPU sleep state and clock gate
`timescale 1ns/10ps
`default_nettype none
module pmw_cpu_gate #(
	parameter int NumIrq = 8
) (
	input  wire logic              clk,
	input  wire logic              resetn,
	input  wire logic [NumIrq-1:0] irq,
	input  wire logic [NumIrq-1:0] irqMask,
	input  wire logic [NumIrq-1:0] deepWakeMask,
	input  wire logic              sleepReq,
	input  wire logic              deepReq,
	input  wire logic              sysDeep,
	input  wire logic              sysReady,
	output logic                   deepWake,
	output logic                   cpuClkEn,
	output pmw_pkg::pmw_cpu_mode_t cpuMode
);
	pmw_pkg::pmw_cpu_mode_t modeD, modeQ;
	logic                   clkEnD, clkEnQ;
	logic                   sleepWake;

	// Controller config decides which deep-sleep irqs reach this CPU
	assign deepWake  = |(irq & deepWakeMask); // [R6]
	assign sleepWake = |(irq & irqMask);

	always_comb begin
		modeD  = modeQ;
		clkEnD = clkEnQ;
		case (modeQ)
			pmw_pkg::PMW_CPU_ACTIVE: begin
				clkEnD = 1'b1;
				if (deepReq) begin
					modeD  = pmw_pkg::PMW_CPU_DEEP;
					clkEnD = 1'b0;
				end else if (sleepReq) begin
					modeD  = pmw_pkg::PMW_CPU_SLEEP;
					clkEnD = 1'b0;
				end
			end
			pmw_pkg::PMW_CPU_SLEEP: begin
				if (sleepWake) begin
					modeD  = pmw_pkg::PMW_CPU_ACTIVE; // [R1]
					clkEnD = 1'b1;
				end
			end
			pmw_pkg::PMW_CPU_DEEP: begin
				// Leaves only once the system is fully up again
				if (deepWake && sysReady && !sysDeep) begin
					modeD  = pmw_pkg::PMW_CPU_ACTIVE; // [R3] [R5]
					clkEnD = 1'b1;
				end
			end
			default: begin
				modeD  = pmw_pkg::PMW_CPU_ACTIVE;
				clkEnD = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			modeQ  <= pmw_pkg::PMW_CPU_ACTIVE;
			clkEnQ <= 1'b1;
		end else begin
			modeQ  <= modeD;
			clkEnQ <= clkEnD;
		end
	end

	assign cpuClkEn = clkEnQ;
	assign cpuMode  = modeQ;
endmodule
`default_nettype wire

// ===== design/pmw_sequencer.sv
// Power mode wakeup sequencer top
// Notes on behaviour
// R1: A sleeping CPU gets its clock back on any interrupt unmasked to it.
// R2: Waking from CPU sleep leaves the system power mode untouched.
// R3: Deep-sleep wake runs regulator, retention release, clocks, then CPU release in order.
// R4: Deep-sleep wake returns to the low-power or ultra-low-power mode held before entry.
// R5: If only one CPU wakes from deep sleep the other stays in CPU deep sleep.
// R6: Each CPU's wakeup controller mask decides whether an interrupt wakes it.
// R7: A wake pin, alarm, watchdog or comparator event in hibernate resets into low-power active.
// R8: The hibernate token and retained data word survive the hibernate wake reset.
// R9: Frozen I/O stays frozen after the wake reset until firmware clears the freeze bit.
// R10: Firmware may copy frozen outputs to the live I/O before unfreezing.
// R11: High-speed clocks run in active and sleep modes and stop in deep sleep and hibernate.
// R12: Freeze and hibernate control writes take effect only with unlock key 0x3a.
// R13: Hibernate wake sources are qualified by polarity and mask before triggering reset; here only pins get polarity, watchdog and comparator neither.
`timescale 1ns/10ps
`default_nettype none
`include "pmw_params.svh"
module pmw_sequencer #(
	parameter int NumIrq    = `PMW_NUM_IRQ,
	parameter int NumHibPin = `PMW_NUM_HIBPIN
) (
	input  wire logic                   clk,
	input  wire logic                   resetn,
	input  wire logic [NumIrq-1:0]      irq,
	input  wire logic [NumIrq-1:0]      irqMask0,
	input  wire logic [NumIrq-1:0]      irqMask1,
	input  wire logic [NumIrq-1:0]      deepWakeMask0,
	input  wire logic [NumIrq-1:0]      deepWakeMask1,
	input  wire logic [1:0]             sleepReq,
	input  wire logic [1:0]             deepReq,
	input  wire logic                   ulpSelect,
	input  wire logic                   hibReq,
	input  wire logic [7:0]             unlockKey,
	input  wire logic                   freezeSet,
	input  wire logic                   freezeClr,
	input  wire logic                   tokenWr,
	input  wire logic [7:0]             tokenIn,
	input  wire logic                   dataWr,
	input  wire logic [31:0]            dataIn,
	input  wire logic [NumHibPin-1:0]   hibPin,
	input  wire logic [NumHibPin-1:0]   hibPinPolarity,
	input  wire logic [NumHibPin-1:0]   hibPinMask,
	input  wire logic                   rtcAlarm,
	input  wire logic                   alarmMask,
	input  wire logic                   wdtIrq,
	input  wire logic                   lpCmpOut,
	output logic                        activeRegEn,
	output logic                        retentionEn,
	output logic                        nonRetResetn,
	output logic                        hsClkEn,
	output logic [1:0]                  cpuClkEn,
	output logic                        sysUlp,
	output logic                        sysDeep,
	output logic                        sysHib,
	output logic                        wakeReset,
	output logic                        ioFrozen,
	output logic [7:0]                  hibToken,
	output logic [31:0]                 hibRetainedWord
);
	////////////////////////////////////////////////////////////////////////////
	localparam logic [3:0] StepCyc = 4'(`PMW_STEP_CYC);
	localparam logic [3:0] RstCyc  = 4'(`PMW_RST_CYC);

	pmw_pkg::pmw_seq_t     seqD, seqQ;
	logic [3:0]            cntD, cntQ;
	logic                  ulpD, ulpQ;
	logic                  regD, regQ, retD, retQ, nrrD, nrrQ, hsD, hsQ;
	logic                  hibD, hibQ, wrstD, wrstQ;
	logic                  sdpD, sdpQ;
	logic [1:0]            deepWake;
	logic [1:0]            clkEnW;
	pmw_pkg::pmw_cpu_mode_t mode0, mode1;
	logic                  sysReady;
	logic                  unlocked;
	logic                  allDeep;
	logic [NumHibPin-1:0]  pinS1, pinS2;
	logic [2:0]            srcS1, srcS2;
	logic                  hibWake;

	////////////////////////////////////////////////////////////////////////////
	// Two-stage sync for the asynchronous wake pins and sources
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pinS1 <= '0;
			pinS2 <= '0;
			srcS1 <= 3'h0;
			srcS2 <= 3'h0;
		end else begin
			pinS1 <= hibPin;
			pinS2 <= pinS1;
			srcS1 <= {rtcAlarm, wdtIrq, lpCmpOut};
			srcS2 <= srcS1;
		end
	end

	// Polarity and mask qualify each pin; a set mask bit enables the source
	assign hibWake = |((pinS2 ^ ~hibPinPolarity) & hibPinMask)
		| (srcS2[2] & alarmMask) | srcS2[1] | srcS2[0]; // [R13] [R7]

	assign unlocked = (unlockKey == `PMW_UNLOCK_KEY); // [R12]

	////////////////////////////////////////////////////////////////////////////
	// Deep CPUs leave only on their own irq: at the end of a wake run, or while the system is up
	assign sysReady = (seqQ == pmw_pkg::PMW_SEQ_CPU)
		|| (seqQ == pmw_pkg::PMW_SEQ_IDLE && regQ && !hibQ && !allDeep); // [R5]

	pmw_cpu_gate #(.NumIrq(NumIrq)) uCpu0 (
		.clk          (clk),
		.resetn       (resetn),
		.irq          (irq),
		.irqMask      (irqMask0),
		.deepWakeMask (deepWakeMask0),
		.sleepReq     (sleepReq[0]),
		.deepReq      (deepReq[0]),
		.sysDeep      (sdpQ),
		.sysReady     (sysReady),
		.deepWake     (deepWake[0]),
		.cpuClkEn     (clkEnW[0]),
		.cpuMode      (mode0)
	);

	pmw_cpu_gate #(.NumIrq(NumIrq)) uCpu1 (
		.clk          (clk),
		.resetn       (resetn),
		.irq          (irq),
		.irqMask      (irqMask1),
		.deepWakeMask (deepWakeMask1),
		.sleepReq     (sleepReq[1]),
		.deepReq      (deepReq[1]),
		.sysDeep      (sdpQ),
		.sysReady     (sysReady),
		.deepWake     (deepWake[1]),
		.cpuClkEn     (clkEnW[1]),
		.cpuMode      (mode1)
	);

	assign allDeep = (mode0 == pmw_pkg::PMW_CPU_DEEP) && (mode1 == pmw_pkg::PMW_CPU_DEEP);

	////////////////////////////////////////////////////////////////////////////
	// System sequencer
	always_comb begin
		seqD  = seqQ;
		cntD  = cntQ;
		ulpD  = ulpQ;
		regD  = regQ;
		retD  = retQ;
		nrrD  = nrrQ;
		hsD   = hsQ;
		hibD  = hibQ;
		wrstD = 1'b0;
		case (seqQ)
			pmw_pkg::PMW_SEQ_IDLE: begin
				// Mode is held through system deep sleep, else follows ulpSelect
				if (!regQ && !hibQ) begin
					ulpD = ulpQ; // [R4]
				end else begin
					ulpD = ulpSelect;
				end
				if (regQ && allDeep) begin
					regD = 1'b0;
					retD = 1'b1;
					nrrD = 1'b0;
					hsD  = 1'b0; // [R11]
				end else if (!regQ && !hibQ && |deepWake) begin
					regD = 1'b1; // [R3]
					seqD = pmw_pkg::PMW_SEQ_REG;
					cntD = StepCyc;
				end else if (regQ && hibReq && unlocked) begin
					hibD = 1'b1; // [R12]
					regD = 1'b0;
					hsD  = 1'b0; // [R11]
					retD = 1'b1;
					nrrD = 1'b0;
				end else if (hibQ && hibWake) begin
					seqD = pmw_pkg::PMW_SEQ_HIBRST; // [R7]
					cntD = RstCyc;
				end
			end
			pmw_pkg::PMW_SEQ_REG: begin
				if (cntQ == 4'h1) begin
					retD = 1'b0;
					nrrD = 1'b1; // [R3]
					seqD = pmw_pkg::PMW_SEQ_RET;
					cntD = StepCyc;
				end else begin
					cntD = cntQ - 4'h1;
				end
			end
			pmw_pkg::PMW_SEQ_RET: begin
				if (cntQ == 4'h1) begin
					hsD  = 1'b1; // [R3] [R11]
					seqD = pmw_pkg::PMW_SEQ_CLK;
					cntD = StepCyc;
				end else begin
					cntD = cntQ - 4'h1;
				end
			end
			pmw_pkg::PMW_SEQ_CLK: begin
				if (cntQ == 4'h1) begin
					seqD = pmw_pkg::PMW_SEQ_CPU; // [R3]
				end else begin
					cntD = cntQ - 4'h1;
				end
			end
			pmw_pkg::PMW_SEQ_CPU: begin
				// One cycle for woken CPUs; mode register untouched [R4]
				seqD = pmw_pkg::PMW_SEQ_IDLE;
			end
			pmw_pkg::PMW_SEQ_HIBRST: begin
				wrstD = 1'b1;
				if (cntQ == 4'h1) begin
					// Reset-to-active lands in low-power active
					hibD = 1'b0;
					ulpD = 1'b0; // [R7]
					regD = 1'b1;
					retD = 1'b0;
					nrrD = 1'b1;
					hsD  = 1'b1;
					seqD = pmw_pkg::PMW_SEQ_IDLE;
				end else begin
					cntD = cntQ - 4'h1;
				end
			end
			default: seqD = pmw_pkg::PMW_SEQ_IDLE;
		endcase
		// Own flop so the deep flag port needs no gate after the registers
		sdpD = ~regD & ~hibD;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			seqQ  <= pmw_pkg::PMW_SEQ_IDLE;
			cntQ  <= 4'h0;
			ulpQ  <= 1'b0;
			regQ  <= 1'b1;
			retQ  <= 1'b0;
			nrrQ  <= 1'b1;
			hsQ   <= 1'b1;
			hibQ  <= 1'b0;
			wrstQ <= 1'b0;
			sdpQ  <= 1'b0;
		end else begin
			seqQ  <= seqD;
			cntQ  <= cntD;
			ulpQ  <= ulpD;
			regQ  <= regD;
			retQ  <= retD;
			nrrQ  <= nrrD;
			hsQ   <= hsD;
			hibQ  <= hibD;
			wrstQ <= wrstD;
			sdpQ  <= sdpD;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Retained state: only resetn clears it, never the wake reset
	logic        frzD, frzQ;
	logic [7:0]  tokD, tokQ;
	logic [31:0] datD, datQ;
	logic [1:0]  cpuEnQ;

	always_comb begin
		frzD = frzQ;
		tokD = tokQ;
		datD = datQ;
		if (freezeSet && unlocked) begin
			frzD = 1'b1; // [R12]
		end else if (freezeClr && unlocked) begin
			frzD = 1'b0; // [R9]
		end
		if (tokenWr) begin
			tokD = tokenIn; // [R8]
		end
		if (dataWr) begin
			datD = dataIn; // [R8]
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			frzQ   <= 1'b0;
			tokQ   <= 8'h00;
			datQ   <= 32'h0000_0000;
			cpuEnQ <= 2'b11;
		end else begin
			frzQ   <= frzD;
			tokQ   <= tokD;
			datQ   <= datD;
			cpuEnQ <= clkEnW;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	assign activeRegEn     = regQ;
	assign retentionEn     = retQ;
	assign nonRetResetn    = nrrQ;
	assign hsClkEn         = hsQ;
	assign cpuClkEn        = cpuEnQ;
	assign sysUlp          = ulpQ;
	assign sysDeep         = sdpQ;
	assign sysHib          = hibQ;
	assign wakeReset       = wrstQ;
	assign ioFrozen        = frzQ;
	assign hibToken        = tokQ;
	assign hibRetainedWord = datQ;
endmodule
`default_nettype wire

// ===== pkg/pmw_params.svh
// Constants for the power mode wakeup sequencer
`ifndef PMW_PARAMS_SVH
`define PMW_PARAMS_SVH
`define PMW_NUM_CPU        2
`define PMW_NUM_IRQ        8
`define PMW_NUM_HIBPIN     4
`define PMW_TOKEN_W        8
`define PMW_DATA_W         32
`define PMW_UNLOCK_KEY     8'h3a
`define PMW_FREEZE_BIT     17
`define PMW_STEP_NS        200
`define PMW_CLK_NS         40
`define PMW_STEP_CYC       ((`PMW_STEP_NS + `PMW_CLK_NS - 1) / `PMW_CLK_NS)
`define PMW_RST_NS         400
`define PMW_RST_CYC        ((`PMW_RST_NS + `PMW_CLK_NS - 1) / `PMW_CLK_NS)
`endif

// ===== pkg/pmw_pkg.sv
// Types for the power mode wakeup sequencer
package pmw_pkg;
	typedef enum logic [1:0] {
		PMW_LP_ACTIVE,
		PMW_ULP_ACTIVE,
		PMW_DEEP_SLEEP,
		PMW_HIBERNATE
	} pmw_sys_mode_t;
	typedef enum logic [1:0] {
		PMW_CPU_ACTIVE,
		PMW_CPU_SLEEP,
		PMW_CPU_DEEP
	} pmw_cpu_mode_t;
	typedef enum logic [2:0] {
		PMW_SEQ_IDLE,
		PMW_SEQ_REG,
		PMW_SEQ_RET,
		PMW_SEQ_CLK,
		PMW_SEQ_CPU,
		PMW_SEQ_HIBRST
	} pmw_seq_t;
endpackage

// ===== verification/pmw_cpu_model.sv
// Two behavioural cores that ask for sleep
`timescale 1ns/10ps
`default_nettype none
module pmw_cpu_model (
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic [1:0] cpuClkEn,
	input  wire logic [1:0] goSleep,
	input  wire logic [1:0] goDeep,
	output logic      [1:0] sleepReq,
	output logic      [1:0] deepReq
);
	// A gated core runs no code, so it cannot ask again
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sleepReq <= 2'h0;
			deepReq  <= 2'h0;
		end else begin
			sleepReq <= goSleep & cpuClkEn;
			deepReq  <= goDeep & cpuClkEn;
		end
	end
endmodule
`default_nettype wire

// ===== verification/pmw_sequencer_assertions.sv
// Port checks for the wakeup sequencer
`timescale 1ns/10ps
`default_nettype none
module pmw_sequencer_assertions #(
	parameter int NumIrq    = 8,
	parameter int NumHibPin = 4
) (
	input wire logic              clk,
	input wire logic              resetn,
	input wire logic [NumIrq-1:0] irq,
	input wire logic [NumIrq-1:0] irqMask0,
	input wire logic [NumIrq-1:0] deepWakeMask0,
	input wire logic [7:0]        unlockKey,
	input wire logic              freezeClr,
	input wire logic              activeRegEn,
	input wire logic              retentionEn,
	input wire logic              nonRetResetn,
	input wire logic              hsClkEn,
	input wire logic [1:0]        cpuClkEn,
	input wire logic              sysUlp,
	input wire logic              sysDeep,
	input wire logic              sysHib,
	input wire logic              wakeReset,
	input wire logic              ioFrozen,
	input wire logic [7:0]        hibToken,
	input wire logic [31:0]       hibRetainedWord
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	////////////////////////////////////////////////////////////////////////////////
	cpu_wake_a: assert property (!cpuClkEn[0] && !sysDeep && !sysHib && !wakeReset && hsClkEn
		&& |(irq & irqMask0 & deepWakeMask0) |-> ##[1:8] cpuClkEn[0])
		else $error("cpu0 not woken");
	reg_first_a: assert property ($fell(retentionEn) |-> activeRegEn)
		else $error("retention released before regulator");
	ret_then_clk_a: assert property ($rose(hsClkEn) |-> !retentionEn && nonRetResetn)
		else $error("clocks before retention release");
	clk_then_cpu_a: assert property ($rose(cpuClkEn[0]) || $rose(cpuClkEn[1]) |-> hsClkEn)
		else $error("cpu released without clocks");
	mode_held_a: assert property (sysDeep |-> $stable(sysUlp))
		else $error("mode lost in deep sleep");
	clk_off_a: assert property ($rose(sysDeep) || (sysHib && !wakeReset) |-> !hsClkEn)
		else $error("fast clocks on in low mode");
	wake_len_a: assert property ($rose(wakeReset) |-> wakeReset [*8])
		else $error("wake reset too short");
	wake_lp_a: assert property ($fell(wakeReset) |-> !sysHib && !sysUlp)
		else $error("not low power active after wake");
	token_kept_a: assert property (wakeReset |-> $stable(hibToken)
		&& $stable(hibRetainedWord))
		else $error("retained state changed");
	freeze_hold_a: assert property (ioFrozen && !(freezeClr && unlockKey == 8'h3a)
		|=> ioFrozen)
		else $error("freeze dropped");
	key_gate_a: assert property (!ioFrozen && unlockKey != 8'h3a |=> !ioFrozen)
		else $error("freeze set without key");
	cover property ($fell(sysDeep));
	cover property ($fell(wakeReset));
	cover property ($fell(ioFrozen));
endmodule
bind pmw_sequencer pmw_sequencer_assertions #(.NumIrq(NumIrq), .NumHibPin(NumHibPin)) chk (
	.clk             (clk),
	.resetn          (resetn),
	.irq             (irq),
	.irqMask0        (irqMask0),
	.deepWakeMask0   (deepWakeMask0),
	.unlockKey       (unlockKey),
	.freezeClr       (freezeClr),
	.activeRegEn     (activeRegEn),
	.retentionEn     (retentionEn),
	.nonRetResetn    (nonRetResetn),
	.hsClkEn         (hsClkEn),
	.cpuClkEn        (cpuClkEn),
	.sysUlp          (sysUlp),
	.sysDeep         (sysDeep),
	.sysHib          (sysHib),
	.wakeReset       (wakeReset),
	.ioFrozen        (ioFrozen),
	.hibToken        (hibToken),
	.hibRetainedWord (hibRetainedWord)
);
`default_nettype wire

// ===== verification/testbench.sv
// Self-checking bench for the wakeup sequencer
`timescale 1ns/10ps
`default_nettype none
module testbench;
	typedef struct packed {logic c; logic [7:0] i; logic [7:0] m; logic w;} pmw_row_t;
	logic clk = 1'b0, resetn = 1'b0, ulpSelect = 1'b1, hibReq = 1'b0;
	logic [7:0] irq = 8'h00, irqMask0 = 8'hff, irqMask1 = 8'hff, unlockKey = 8'h00;
	logic [7:0] deepWakeMask0 = 8'hff, deepWakeMask1 = 8'hff, tokenIn = 8'h00, hibToken;
	logic freezeSet = 1'b0, freezeClr = 1'b0, tokenWr = 1'b0, dataWr = 1'b0;
	logic [31:0] dataIn = 32'h0, hibRetainedWord;
	logic [3:0] hibPin = 4'h8, hibPinPolarity = 4'h7, hibPinMask = 4'h8;
	logic rtcAlarm = 1'b0, alarmMask = 1'b1, wdtIrq = 1'b0, lpCmpOut = 1'b0;
	logic [1:0] goSleep = 2'h0, goDeep = 2'h0, sleepReq, deepReq, cpuClkEn;
	logic activeRegEn, retentionEn, nonRetResetn, hsClkEn, sysUlp, sysDeep, sysHib;
	logic wakeReset, ioFrozen;
	int checks = 0, num_errors = 0, cycles = 0;
	pmw_row_t rows [4] = '{'{1'b0, 8'h01, 8'h01, 1'b1}, '{1'b0, 8'h80, 8'h7f, 1'b0},
		'{1'b1, 8'h10, 8'h10, 1'b1}, '{1'b1, 8'h02, 8'h00, 1'b0}};
	pmw_sequencer uut (.*);
	pmw_cpu_model cpus (.*);
	always #20 clk = ~clk;
	////////////////////////////////////////////////////////////////////////////////
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic check(input logic ok, input string msg);
		checks++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d num_errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic hib_wake(input int src);
		logic [7:0] tok;
		tok = 8'h5a + 8'(src);
		unlockKey = 8'h3a;
		tokenWr = 1'b1;
		dataWr = 1'b1;
		freezeSet = 1'b1;
		tokenIn = tok;
		dataIn = {24'hc0de00, tok};
		tick(1);
		{tokenWr, dataWr, freezeSet, hibReq} = 4'h1;
		tick(1);
		hibReq = 1'b0;
		tick(3);
		check(sysHib === 1'b1 && hsClkEn === 1'b0, "hib entry");
		case (src)
			0: begin
				hibPin = 4'h9;
				tick(6);
				check(wakeReset === 1'b0 && sysHib === 1'b1, "masked pin");
				hibPin = 4'h0;
			end
			1: begin
				alarmMask = 1'b0;
				rtcAlarm = 1'b1;
				tick(6);
				check(wakeReset === 1'b0 && sysHib === 1'b1, "masked alarm");
				alarmMask = 1'b1;
			end
			2: wdtIrq = 1'b1;
			default: lpCmpOut = 1'b1;
		endcase
		for (int i = 0; i < 10 && wakeReset !== 1'b1; i++) tick(1);
		check(wakeReset === 1'b1, "wake reset");
		{hibPin, rtcAlarm, wdtIrq, lpCmpOut} = 7'h40;
		for (int i = 0; i < 40 && wakeReset !== 1'b0; i++) tick(1);
		tick(2);
		check(sysUlp === 1'b0 && sysHib === 1'b0 && cpuClkEn === 2'h3, "to lp");
		check(hibToken === tok && hibRetainedWord === {24'hc0de00, tok}, "kept");
		check(ioFrozen === 1'b1, "still frozen");
		// Bench plays firmware: clear without key first, then unfreeze with it
		unlockKey = 8'h00;
		freezeClr = 1'b1;
		tick(1);
		freezeClr = 1'b0;
		tick(2);
		check(ioFrozen === 1'b1, "clear without key");
		unlockKey = 8'h3a;
		freezeClr = 1'b1;
		tick(1);
		freezeClr = 1'b0;
		tick(2);
		check(ioFrozen === 1'b0, "unfreeze");
	endtask
	////////////////////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			$display("wrong value at %0t: timeout", $time);
			end_of_test();
		end
	end
	initial begin
		tick(16);
		resetn = 1'b1;
		tick(2);
		check(hsClkEn === 1'b1 && cpuClkEn === 2'h3 && ioFrozen === 1'b0, "reset");
		foreach (rows[i]) begin
			irqMask0 = rows[i].c ? 8'hff : rows[i].m;
			irqMask1 = rows[i].c ? rows[i].m : 8'hff;
			goSleep[rows[i].c] = 1'b1;
			tick(1);
			goSleep = 2'h0;
			tick(3);
			check(cpuClkEn[rows[i].c] === 1'b0, "sleep entry");
			irq = rows[i].i;
			tick(4);
			check(cpuClkEn[rows[i].c] === rows[i].w, "sleep wake");
			check(sysUlp === 1'b1 && sysDeep === 1'b0, "mode kept");
			{irqMask0, irqMask1} = 16'hffff;
			tick(4);
			irq = 8'h00;
		end
		deepWakeMask0 = 8'h01;
		deepWakeMask1 = 8'h02;
		goDeep = 2'h3;
		tick(1);
		goDeep = 2'h0;
		tick(4);
		check(sysDeep === 1'b1 && hsClkEn === 1'b0 && retentionEn === 1'b1, "deep");
		irq = 8'h01;
		for (int i = 0; i < 40 && cpuClkEn[0] !== 1'b1; i++) tick(1);
		check(cpuClkEn === 2'h1 && sysDeep === 1'b0 && hsClkEn === 1'b1, "one");
		check(sysUlp === 1'b1, "ulp restored");
		irq = 8'h02;
		tick(12);
		check(cpuClkEn === 2'h3, "second cpu");
		irq = 8'h00;
		ulpSelect = 1'b0;
		{hibReq, freezeSet} = 2'h3;
		tick(1);
		{hibReq, freezeSet} = 2'h0;
		tick(3);
		check(sysHib === 1'b0 && ioFrozen === 1'b0, "no key");
		for (int s = 0; s < 4; s++) hib_wake(s);
		// Power-on reset, unlike the wake reset, clears the retained state
		resetn = 1'b0;
		tick(2);
		resetn = 1'b1;
		tick(2);
		check(hibToken === 8'h00 && hibRetainedWord === 32'h0 && ioFrozen === 1'b0, "por");
		check(hsClkEn === 1'b1 && cpuClkEn === 2'h3 && sysDeep === 1'b0, "por state");
		end_of_test();
	end
endmodule
`default_nettype wire
